//--- csrp_pkg.sv
/*
 package for the chained serial remote port: framing counts, control codes,
 remote/local states and the carried struct.
 assumes a single 25 MHz clock shared by every file that imports it.
*/
package csrp_pkg;
    localparam int          CLK_HZ        = 25000000;
    localparam int          BAUD_DEFAULT  = 9600;
    localparam int          DATA_BITS     = 8;
    localparam logic [4:0]  ADDR_FORBID   = 5'h1f;
    localparam logic [4:0]  ADDR_RESET    = 5'h05;
    localparam int          CHAIN_MAX     = 32;
    localparam logic [7:0]  CODE_SPACE    = 8'h20;
    localparam logic [7:0]  CODE_LF       = 8'h0a;
    localparam logic [7:0]  CODE_CR       = 8'h0d;
    localparam logic [7:0]  CODE_XON      = 8'h11;
    localparam logic [7:0]  CODE_XOFF     = 8'h13;
    localparam logic [7:0]  CODE_LISTEN   = 8'h12;
    localparam logic [7:0]  CODE_TALK     = 8'h14;
    localparam logic [7:0]  CODE_UNADDR   = 8'h03;
    localparam logic [7:0]  CODE_CLEAR    = 8'h18;
    localparam logic [7:0]  CODE_ACK      = 8'h06;
    localparam logic [7:0]  CASE_MASK     = 8'hdf;

    typedef enum logic {CSRP_LOCAL, CSRP_REMOTE} csrp_mode_type;

    // one decoded character handed to the command parser
    typedef struct packed {
        logic       valid;
        logic       is_ctrl;
        logic       is_term;
        logic [7:0] data;
    } csrp_char_type;
endpackage

//--- csrp_uart.sv
/*
 one 8N1 serial channel: receiver and transmitter, fixed framing.
 assumes rx is synchronous to clk and idles high; divisor set by parameter.
*/
`timescale 1ns/1ps
module csrp_uart
    import csrp_pkg::*;
#(
    parameter int DIV = CLK_HZ / BAUD_DEFAULT
)
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // serial pins
    input  wire logic       rx_i,
    output logic            tx_o,
    // receive side
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    // transmit side
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o
);
    localparam int W = $clog2(DIV + 1);
    logic [W-1:0] rcnt_q;
    logic [3:0]   rbit_q;
    logic [8:0]   rsh_q;
    logic         rbusy_q;
    logic [W-1:0] tcnt_q;
    logic [3:0]   tbit_q;
    logic [9:0]   tsh_q;

    // receiver, mid-bit sampling, fixed 1 start, 8 data, 1 stop
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rbusy_q    <= 1'b0;
            rcnt_q     <= '0;
            rbit_q     <= '0;
            rsh_q      <= '0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= 8'h00;
        end
        else
        begin
            rx_valid_o <= 1'b0;
            if (!rbusy_q)
            begin
                if (!rx_i)
                begin
                    rbusy_q <= 1'b1;
                    rcnt_q  <= W'(DIV / 2);
                    rbit_q  <= '0;
                end
            end
            else if (rcnt_q != '0)
                rcnt_q <= rcnt_q - 1'b1;
            else
            begin
                rcnt_q <= W'(DIV - 1);
                rbit_q <= rbit_q + 1'b1;
                rsh_q  <= {rx_i, rsh_q[8:1]};
                if (rbit_q == 4'd0 && rx_i)
                    rbusy_q <= 1'b0;          // false start
                else if (rbit_q == 4'd9)
                begin
                    rbusy_q <= 1'b0;
                    if (rx_i)
                    begin
                        rx_valid_o <= 1'b1;
                        rx_data_o  <= rsh_q[8:1];
                    end
                end
            end
        end
    end

    // transmitter
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tx_o       <= 1'b1;
            tx_ready_o <= 1'b1;
            tcnt_q     <= '0;
            tbit_q     <= '0;
            tsh_q      <= '1;
        end
        else if (tx_ready_o)
        begin
            if (tx_valid_i)
            begin
                tsh_q      <= {1'b1, tx_data_i, 1'b0};
                tx_ready_o <= 1'b0;
                tcnt_q     <= '0;
                tbit_q     <= '0;
            end
        end
        else if (tcnt_q != '0)
            tcnt_q <= tcnt_q - 1'b1;
        else
        begin
            tx_o   <= tsh_q[0];
            tsh_q  <= {1'b1, tsh_q[9:1]};
            tcnt_q <= W'(DIV - 1);
            tbit_q <= tbit_q + 1'b1;
            if (tbit_q == 4'd10)
            begin
                tx_ready_o <= 1'b1;
                tx_o       <= 1'b1;
            end
        end
    end
endmodule

//--- csrp_top.sv
/*
 chained serial remote port: primary and secondary 8N1 channels, chain relay,
 listen addressing, software flow control, remote/local tracking, bus select.
 assumes synchronous serial inputs and a response source that honours ready.
*/
`timescale 1ns/1ps
// How it works
// - power-on enters local state, remote lamp off, keys usable
// - addressed listener receiving a command goes remote and locks keys
// - local key holds only until the next character received while addressed as listener
// - address 31 is refused for both buses
// - frames are fixed one start, eight data, no parity, one stop
// - no handshake wires; flow control is in-band only
// - received bit seven is forced to zero for decoding; the chain relay passes it on unchanged
// - command letters compared regardless of case
// - codes below space are interface control, not text
// - chain holds at most thirty-two instruments
// - all members powered at common baud or downstream hears nothing
// - primary pair is a plain port; secondary pair used when chained
// - one primary parallel-bus address, no secondary addressing
// - selecting an absent parallel bus errors and keeps serial
// - stop code suspends our talker until restart code arrives
// - line feed ends every command and every response
// - carriage return is kept from the parser but still relayed down the chain and still clears a pending listen code
// - listen code plus address character selects a listener
module csrp_top
    import csrp_pkg::*;
#(
    parameter int DIV = CLK_HZ / BAUD_DEFAULT
)
(
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // primary serial pair, host side
    input  wire logic       rx_i,
    output logic            tx_o,
    // chain pair, next instrument
    input  wire logic       secondary_receive_line_i,
    output logic            secondary_transmit_line_o,
    // front panel and configuration
    input  wire logic       local_key_i,
    input  wire logic       addr_wr_i,
    input  wire logic [4:0] addr_i,
    input  wire logic       par_sel_req_i,
    input  wire logic       par_sel_val_i,
    input  wire logic       par_fitted_i,
    // responses to send when talking
    input  wire logic       resp_valid_i,
    input  wire logic [7:0] resp_data_i,
    output logic            resp_ready_o,
    // status
    output logic            remote_o,
    output logic            keys_locked_o,
    output logic            listening_o,
    output logic            par_selected_o,
    output logic            sel_error_o,
    output logic [4:0]      addr_o,
    output csrp_char_type   cmd_o
);
    logic          p_rx_v, s_rx_v, p_tx_rdy, s_tx_rdy;
    logic [7:0]    p_rx_d, s_rx_d;
    logic          p_tx_v, s_tx_v;
    logic [7:0]    p_tx_d, s_tx_d;
    logic [7:0]    ch;
    logic          addr_next_q, xoff_q, ack_pend_q, relay_pend_q;
    logic [7:0]    relay_d_q, fwd_d_q;
    logic          fwd_pend_q;
    csrp_mode_type mode_q;

    csrp_uart #(.DIV(DIV)) u_pri (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .rx_i       (rx_i),
        .tx_o       (tx_o),
        .rx_valid_o (p_rx_v),
        .rx_data_o  (p_rx_d),
        .tx_valid_i (p_tx_v),
        .tx_data_i  (p_tx_d),
        .tx_ready_o (p_tx_rdy)
    );

    csrp_uart #(.DIV(DIV)) u_sec (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .rx_i       (secondary_receive_line_i),
        .tx_o       (secondary_transmit_line_o),
        .rx_valid_o (s_rx_v),
        .rx_data_o  (s_rx_d),
        .tx_valid_i (s_tx_v),
        .tx_data_i  (s_tx_d),
        .tx_ready_o (s_tx_rdy)
    );

    assign ch = {1'b0, p_rx_d[6:0]};

    // chain relay; one-character holding stage each way, a new character overwrites the held one
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fwd_pend_q   <= 1'b0;
            fwd_d_q      <= 8'h00;
            relay_pend_q <= 1'b0;
            relay_d_q    <= 8'h00;
        end
        else
        begin
            if (p_rx_v)
            begin
                fwd_pend_q <= 1'b1;
                fwd_d_q    <= p_rx_d;
            end
            else if (s_tx_v)
                fwd_pend_q <= 1'b0;
            if (s_rx_v)
            begin
                relay_pend_q <= 1'b1;
                relay_d_q    <= s_rx_d;
            end
            else if (p_tx_v && !ack_pend_q)
                relay_pend_q <= 1'b0;
        end
    end

    assign s_tx_v = fwd_pend_q && s_tx_rdy;
    assign s_tx_d = fwd_d_q;

    // primary tx arbitration: ack, then relay, then our response unless held off
    always_comb
    begin
        p_tx_v       = 1'b0;
        p_tx_d       = resp_data_i;
        resp_ready_o = 1'b0;
        if (p_tx_rdy)
        begin
            if (ack_pend_q)
            begin
                p_tx_v = 1'b1;
                p_tx_d = CODE_ACK;
            end
            else if (relay_pend_q)
            begin
                p_tx_v = 1'b1;
                p_tx_d = relay_d_q;
            end
            else if (!xoff_q && resp_valid_i)
            begin
                p_tx_v       = 1'b1;
                resp_ready_o = 1'b1;
            end
        end
    end

    // flow control from the listener
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            xoff_q <= 1'b0;
        else if (p_rx_v && ch == CODE_XOFF)
            xoff_q <= 1'b1;
        else if (p_rx_v && ch == CODE_XON)
            xoff_q <= 1'b0;
    end

    // address configuration
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            addr_o <= ADDR_RESET;
        else if (addr_wr_i && addr_i != ADDR_FORBID)
            addr_o <= addr_i;
    end

    // listen addressing
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            addr_next_q <= 1'b0;
            listening_o <= 1'b0;
            ack_pend_q  <= 1'b0;
        end
        else
        begin
            if (ack_pend_q && p_tx_rdy)
                ack_pend_q <= 1'b0;
            if (p_rx_v)
            begin
                addr_next_q <= (ch == CODE_LISTEN);
                if (addr_next_q)
                begin
                    listening_o <= (ch[4:0] == addr_o) && (ch[4:0] != ADDR_FORBID);
                    ack_pend_q  <= (ch[4:0] == addr_o);
                end
                else if (ch == CODE_TALK || ch == CODE_UNADDR || ch == CODE_CLEAR)
                    listening_o <= 1'b0;
            end
        end
    end

    // remote/local state
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            mode_q <= CSRP_LOCAL;
        else if (p_rx_v && listening_o)
            mode_q <= CSRP_REMOTE;
        else if (local_key_i)
            mode_q <= CSRP_LOCAL;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            remote_o      <= 1'b0;
            keys_locked_o <= 1'b0;
        end
        else
        begin
            remote_o      <= (mode_q == CSRP_REMOTE);
            keys_locked_o <= (mode_q == CSRP_REMOTE) && !local_key_i;
        end
    end

    // character filter toward the parser
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            cmd_o <= '0;
        else
        begin
            cmd_o.valid   <= p_rx_v && listening_o && ch != CODE_CR;
            cmd_o.is_ctrl <= ch < CODE_SPACE;
            cmd_o.is_term <= ch == CODE_LF;
            cmd_o.data    <= (ch >= 8'h61 && ch <= 8'h7a) ? (ch & CASE_MASK) : ch;
        end
    end

    // interface selection
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            par_selected_o <= 1'b0;
            sel_error_o    <= 1'b0;
        end
        else
        begin
            sel_error_o <= 1'b0;
            if (par_sel_req_i)
            begin
                if (par_sel_val_i && !par_fitted_i)
                begin
                    sel_error_o    <= 1'b1;
                    par_selected_o <= 1'b0;
                end
                else
                    par_selected_o <= par_sel_val_i;
            end
        end
    end

    // chain length and baud agreement are system properties; nothing to gate here
    // are met by the two pairs above

    sequence s_listen_hit;
        p_rx_v && listening_o;
    endsequence

    property p_local_reset;
        @(posedge clock_i) $fell(rst_i) |-> !remote_o;
    endproperty
    a_local_reset: assert property (p_local_reset) else $error("not local after reset");

    property p_go_remote;
        @(posedge clock_i) disable iff (rst_i) s_listen_hit |-> ##2 remote_o;
    endproperty
    a_go_remote: assert property (p_go_remote) else $error("no remote after command");

    property p_local_key;
        @(posedge clock_i) disable iff (rst_i) local_key_i && !p_rx_v |-> ##2 !remote_o;
    endproperty
    a_local_key: assert property (p_local_key) else $error("local key ignored");

    property p_no_31;
        @(posedge clock_i) disable iff (rst_i) addr_o != ADDR_FORBID;
    endproperty
    a_no_31: assert property (p_no_31) else $error("forbidden address held");

    property p_xoff_hold;
        @(posedge clock_i) disable iff (rst_i) xoff_q |-> !resp_ready_o;
    endproperty
    a_xoff_hold: assert property (p_xoff_hold) else $error("sent while held off");

    property p_bit7;
        @(posedge clock_i) disable iff (rst_i) cmd_o.valid |-> !cmd_o.data[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit seven passed");

    property p_par_err;
        @(posedge clock_i) disable iff (rst_i)
            par_sel_req_i && par_sel_val_i && !par_fitted_i |=> sel_error_o && !par_selected_o;
    endproperty
    a_par_err: assert property (p_par_err) else $error("absent bus selected");

    property p_relay;
        @(posedge clock_i) disable iff (rst_i) p_rx_v |=> fwd_pend_q && fwd_d_q == $past(p_rx_d);
    endproperty
    a_relay: assert property (p_relay) else $error("chain relay lost");

    property p_case;
        @(posedge clock_i) disable iff (rst_i) cmd_o.valid |-> !(cmd_o.data inside {[8'h61:8'h7a]});
    endproperty
    a_case: assert property (p_case) else $error("lower case passed");
endmodule

//--- csrp_host_model.sv
/*
 far-side serial model: one 8n1 sender and one receiver on a line pair.
 assumes the design clock and DIV clocks per bit on both ends.
*/
`timescale 1ns/1ps
module csrp_host_model
    import csrp_pkg::*;
#(
    parameter int DIV = 8
)
(
    // clock
    input  wire logic       clock_i,
    // line pair
    input  wire logic       line_i,
    output logic            line_o,
    // received characters
    output logic            got_o,
    output logic [7:0]      got_data_o
);
    logic [7:0] sh;

    // line idles at mark; no handshake wires at all
    initial
    begin
        line_o = 1'b1;
        got_o = 1'b0;
        got_data_o = 8'h00;
    end

    // one divisor shared by every chain member
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        @(posedge clock_i);
        for (int i = 0; i < 10; i++)
        begin
            line_o <= f[i];
            repeat (DIV) @(posedge clock_i);
        end
    endtask

    // bad stop bit drops the character, as a real receiver would
    initial
    begin
        forever
        begin
            @(negedge line_i);
            repeat (DIV / 2) @(posedge clock_i);
            for (int i = 0; i < 8; i++)
            begin
                repeat (DIV) @(posedge clock_i);
                sh[i] = line_i;
            end
            repeat (DIV) @(posedge clock_i);
            if (line_i === 1'b1)
            begin
                got_data_o <= sh;
                got_o <= 1'b1;
                @(posedge clock_i);
                got_o <= 1'b0;
            end
        end
    end
endmodule

//--- test_csrp_top.sv
/*
 testbench for the chained serial remote port: host and chain models, queued results.
 assumes the design carries its own assertions; DIV shortened for simulation.
*/
`timescale 1ns/1ps
module test_csrp_top;
    import csrp_pkg::*;
    localparam int DIV = 8;
    logic          clock_i, rst_i, rx_i, tx_o, sec_rx, sec_tx, local_key_i, addr_wr_i;
    logic          par_sel_req_i, par_sel_val_i, par_fitted_i, resp_valid_i, resp_ready_o;
    logic          remote_o, keys_locked_o, listening_o, par_selected_o, sel_error_o;
    logic          h_got, d_got;
    logic [4:0]    addr_i, addr_o, a;
    logic [7:0]    resp_data_i, h_data, d_data, c, e;
    logic [7:0]    exp_cmd[$], exp_host[$], exp_down[$];
    csrp_char_type cmd_o;
    int            n_errors, n_checks, seed;

    csrp_top #(.DIV(DIV)) i_dut (.clock_i(clock_i), .rst_i(rst_i), .rx_i(rx_i), .tx_o(tx_o),
        .secondary_receive_line_i(sec_rx), .secondary_transmit_line_o(sec_tx),
        .local_key_i(local_key_i), .addr_wr_i(addr_wr_i), .addr_i(addr_i),
        .par_sel_req_i(par_sel_req_i), .par_sel_val_i(par_sel_val_i), .par_fitted_i(par_fitted_i),
        .resp_valid_i(resp_valid_i), .resp_data_i(resp_data_i), .resp_ready_o(resp_ready_o),
        .remote_o(remote_o), .keys_locked_o(keys_locked_o), .listening_o(listening_o),
        .par_selected_o(par_selected_o), .sel_error_o(sel_error_o), .addr_o(addr_o), .cmd_o(cmd_o));
    csrp_host_model #(.DIV(DIV)) i_host (.clock_i(clock_i), .line_i(tx_o), .line_o(rx_i),
        .got_o(h_got), .got_data_o(h_data));
    csrp_host_model #(.DIV(DIV)) i_down (.clock_i(clock_i), .line_i(sec_tx), .line_o(sec_rx),
        .got_o(d_got), .got_data_o(d_data));

    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic logic [7:0] pop(ref logic [7:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 8'hxx;
    endfunction

    // letters compared with case folded; bit seven kept so a leak shows
    function automatic logic [7:0] fold(input logic [7:0] v);
        return (v[6] === 1'b1 && v[4:0] != 5'h00 && v[4:0] <= 5'h1a) ? (v & 8'hdf) : v;
    endfunction

    // every host character is relayed down the chain
    task automatic host_send(input logic [7:0] v, input logic shown);
        exp_down.push_back(v);
        if (shown)
            exp_cmd.push_back(v & 8'h7f);
        i_host.send(v);
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic pulse(input logic wr, input logic sel, input logic [4:0] v);
        @(posedge clock_i);
        addr_wr_i <= wr;
        par_sel_req_i <= sel;
        addr_i <= v;
        par_sel_val_i <= v[0];
        @(posedge clock_i);
        addr_wr_i <= 1'b0;
        par_sel_req_i <= 1'b0;
        @(negedge clock_i);
    endtask

    task automatic respond(input logic [7:0] v);
        exp_host.push_back(v);
        @(posedge clock_i);
        resp_valid_i <= 1'b1;
        resp_data_i <= v;
        for (int k = 0; k < 2000 && resp_ready_o !== 1'b1; k++)
            @(negedge clock_i);
        @(posedge clock_i);
        resp_valid_i <= 1'b0;
    endtask

    always @(posedge clock_i)
    begin
        if (cmd_o.valid === 1'b1 && (cmd_o.is_ctrl !== 1'b1 || cmd_o.data === CODE_LF))
        begin
            e = pop(exp_cmd);
            check(fold(cmd_o.data), fold(e));
            check({6'h0, cmd_o.is_ctrl, cmd_o.is_term}, {6'h0, e < CODE_SPACE, e == CODE_LF});
        end
        if (h_got === 1'b1)
            check(h_data, pop(exp_host));
        if (d_got === 1'b1)
            check(d_data, pop(exp_down));
    end

    // about twenty characters of eighty cycles each, with ample margin
    initial
    begin
        repeat (30000) @(posedge clock_i);
        n_errors++;
        stop_test();
    end

    initial
    begin
        seed = 32'h9fd0c6fb;
        {rst_i, local_key_i, addr_wr_i, par_sel_req_i, par_sel_val_i, par_fitted_i, resp_valid_i} = 7'h40;
        addr_i = 5'h00;
        resp_data_i = 8'h00;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check({remote_o, keys_locked_o, listening_o, sel_error_o, tx_o, sec_tx}, 8'h03);
        check({3'h0, addr_o}, {3'h0, ADDR_RESET});
        pulse(1'b1, 1'b0, ADDR_FORBID);
        check({3'h0, addr_o}, {3'h0, ADDR_RESET});
        a = 5'((($random(seed)) & 32'h7fff) % 31);
        pulse(1'b1, 1'b0, a);
        check({3'h0, addr_o}, {3'h0, a});
        pulse(1'b0, 1'b1, 5'h01);
        check({6'h0, sel_error_o, par_selected_o}, 8'h02);
        par_fitted_i <= 1'b1;
        pulse(1'b0, 1'b1, 5'h01);
        check({6'h0, sel_error_o, par_selected_o}, 8'h01);
        pulse(1'b0, 1'b1, 5'h00);
        check({6'h0, sel_error_o, par_selected_o}, 8'h00);
        host_send(CODE_LISTEN, 1'b0);
        host_send({3'b010, a ^ 5'h01}, 1'b0);
        check({7'h0, listening_o}, 8'h00);
        exp_host.push_back(CODE_ACK);
        host_send(CODE_LISTEN, 1'b0);
        host_send({3'b010, a}, 1'b0);
        check({6'h0, listening_o, remote_o}, 8'h02);
        for (int i = 0; i < 6; i++)
        begin
            c = 8'h41 + 8'((($random(seed)) & 32'hff) % 26);
            host_send(c | (8'($random(seed)) & 8'ha0), 1'b1);
            if (i == 2)
                host_send(CODE_CR, 1'b0);
        end
        check({6'h0, remote_o, keys_locked_o}, 8'h03);
        host_send(CODE_LF, 1'b1);
        @(posedge clock_i);
        local_key_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        local_key_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check({6'h0, remote_o, keys_locked_o}, 8'h00);
        host_send(8'h7a, 1'b1);
        check({6'h0, remote_o, keys_locked_o}, 8'h03);
        host_send(CODE_XOFF, 1'b0);
        @(posedge clock_i);
        resp_valid_i <= 1'b1;
        resp_data_i <= 8'h52;
        repeat (30 * DIV) @(posedge clock_i);
        @(negedge clock_i);
        check({7'h0, resp_ready_o}, 8'h00);
        resp_valid_i <= 1'b0;
        host_send(CODE_XON, 1'b0);
        respond(8'h52);
        respond(CODE_LF);
        host_send(CODE_UNADDR, 1'b0);
        check({7'h0, listening_o}, 8'h00);
        host_send(8'h71, 1'b0);
        exp_host.push_back(8'h4b);
        exp_host.push_back(8'h0a);
        i_down.send(8'h4b);
        i_down.send(8'h0a);
        repeat (30 * DIV) @(posedge clock_i);
        check(8'(exp_cmd.size() + exp_host.size() + exp_down.size()), 8'h00);
        stop_test();
    end
endmodule
